// ### verification/rslb_log_bank_monitor.sv
`timescale 1ns/1ps
module rslb_log_bank_monitor (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic active_control_in,
   input wire logic sleep_control_in,
   input wire logic rd_en_in,
   input wire logic [7:0] rd_addr_in,
   input wire logic [7:0] rd_data_out,
   input wire logic rd_valid_out,
   input wire logic seq_active_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   sequence read_taken;
      rd_en_in;
   endsequence
   sequence read_ends;
      rd_en_in ##1 !rd_en_in;
   endsequence
   sequence ctl_moved;
      ($past(active_control_in, 5) != $past(active_control_in, 6))
         || ($past(sleep_control_in, 5) != $past(sleep_control_in, 6));
   endsequence
   read_answer_a: assert property (read_taken |=> rd_valid_out) else $error("read unanswered");
   single_answer_a: assert property (read_ends |=> !rd_valid_out) else $error("answer too long");
   data_hold_a: assert property (!rd_valid_out |-> $stable(rd_data_out)) else $error("data moved");
   quiet_start_a: assert property ($rose(seq_active_out) |-> ctl_moved) else $error("stray sequence");
   answer_cause_a: assert property (rd_valid_out |-> $past(rd_en_in)) else $error("stray valid");
   hole_read_a: assert property (rd_en_in && rd_addr_in == 8'h88 |=> rd_data_out == 8'h00)
      else $error("hole not zero");
endmodule : rslb_log_bank_monitor

// ### verification/rslb_log_bank_tb.sv
`timescale 1ns/1ps
module rslb_log_bank_tb;
   logic clk = 0, rst = 1, act = 1, slp = 1, uv = 1, rd_en = 0, v;
   localparam int STEP = 4;
   logic [7:0] tag = 8'h00, addr = 8'h00, q;
   logic [3:0] fall = 4'h0, below;
   int err_total = 0, n_checks = 0;
   always #20 clk = ~clk;
   rslb_rails u_rslb_rails (.ref_clk_in(clk), .fall_in(fall), .below_out(below));
   rslb_log_bank #(.STEP_CYCLES(STEP)) u_rslb_log_bank (.ref_clk_in(clk), .srst_in(rst),
      .active_control_in(act), .sleep_control_in(slp), .rail_tag_counter_in(tag),
      .entry_ch_below_off_in(below), .ch1_below_off_in(fall[0]), .ch1_above_uv_low_in(uv),
      .rd_en_in(rd_en), .rd_addr_in(addr), .rd_data_out(q), .rd_valid_out(v), .seq_active_out());
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one-cycle request, answer stands only in the following cycle
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk) rd_en = 1;
      addr = a;
      @(negedge clk) rd_en = 0;
      check("rd_valid", {7'h00, v}, 8'h01);
      check("rd_data", q, exp);
   endtask : rd
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (4) @(negedge clk);
      rst = 0; // nothing is read before a sequence has logged it
      repeat (8) @(negedge clk);
      slp = 0;
      for (int i = 0; i < 4; i++) begin
         tag = 8'(8'h11 * (i + 1));
         fall[i] = 1;
         repeat (10) @(negedge clk);
      end
      for (int i = 0; i < 4; i++) rd(8'(8'h84 + i), 8'(8'h11 * (i + 1)));
      rd(8'h90, 8'h00);
      rd(8'h91, 8'h00);
      rd(8'h88, 8'h00);
      // active control falling must leave the sleep-entry tags alone
      slp = 1;
      fall = 4'h0;
      repeat (10) @(negedge clk);
      act = 0;
      tag = 8'h77;
      fall = 4'hF;
      repeat (10) @(negedge clk);
      rd(8'h84, 8'h11);
      // power-on: ch1 reaches undervoltage-low 40 clocks after the start
      uv = 0;
      fall = 4'h0;
      repeat (10) @(negedge clk);
      act = 1;
      repeat (40) @(negedge clk);
      uv = 1;
      repeat (10) @(negedge clk);
      rd(8'h91, 8'(40 / STEP));
      rd(8'h90, 8'h00);
      give_verdict();
   end
endmodule : rslb_log_bank_tb
bind rslb_log_bank rslb_log_bank_monitor u_rslb_log_bank_monitor (.*);

// ### verification/rslb_rails.sv
`timescale 1ns/1ps
// rails fall through the off threshold one clock after the bench commands it
module rslb_rails (
   input wire logic ref_clk_in,
   input wire logic [3:0] fall_in,
   output logic [3:0] below_out
);
   always_ff @(posedge ref_clk_in) below_out <= fall_in;
endmodule : rslb_rails

// ### verilog/rslb_log_bank.sv
`timescale 1ns/1ps
// Behaviour
// - four read-only 8-bit sleep-entry order registers, channels 5-8, 0x84-0x87
// - order tags captured only in the sequence begun by sleep control falling
// - tag taken when the rail falls through the 200mV off threshold
// - stored tag equals rail tag counter value at the crossing
// - channel 1 timestamp high byte readable at 0x90
// - power-on and sleep-exit: timestamp stored on rising undervoltage-low crossing
// - power-off and sleep-entry: timestamp stored on falling off-threshold crossing
// - timer step is 50us
// - log contents undefined until a sequence records them; host must not rely
// - channel 1 timestamp low byte readable at 0x91
module rslb_log_bank #(
   parameter int STEP_CYCLES = rslb_pkg::RSLB_STEP_CYCLES
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic active_control_in,
   input wire logic sleep_control_in,
   input wire logic [7:0] rail_tag_counter_in,
   input wire logic [3:0] entry_ch_below_off_in,
   input wire logic ch1_below_off_in,
   input wire logic ch1_above_uv_low_in,
   input wire logic rd_en_in,
   input wire logic [7:0] rd_addr_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output logic seq_active_out
);
   localparam int NCH = rslb_pkg::RSLB_NUM_ENTRY_CH;
   localparam int DW = rslb_pkg::RSLB_DATA_W;
   localparam int TSW = rslb_pkg::RSLB_TS_W;
   localparam int NSYNC = 4 + NCH;
   localparam int PRE_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
   localparam int SET_W = $clog2(rslb_pkg::RSLB_SETTLE_CYCLES + 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);
   localparam logic [SET_W-1:0] SET_LAST = SET_W'(rslb_pkg::RSLB_SETTLE_CYCLES);
   localparam logic [TSW-1:0] TS_MAX = '1;

   // pin edges: level now against level one clock ago
   function automatic logic rslb_rise(input logic now_v, input logic prev_v);
      return now_v & ~prev_v;
   endfunction : rslb_rise

   function automatic logic rslb_fall(input logic now_v, input logic prev_v);
      return ~now_v & prev_v;
   endfunction : rslb_fall

   function automatic logic rslb_hit(input logic [7:0] addr_v, input logic [7:0] ofs_v);
      return addr_v == ofs_v;
   endfunction : rslb_hit

   function automatic logic [7:0] rslb_order_ofs(input int idx);
      logic [7:0] ofs_v;
      ofs_v = rslb_pkg::RSLB_OFS_ORDER_CH5;
      case (idx)
         0: ofs_v = rslb_pkg::RSLB_OFS_ORDER_CH5;
         1: ofs_v = rslb_pkg::RSLB_OFS_ORDER_CH6;
         2: ofs_v = rslb_pkg::RSLB_OFS_ORDER_CH7;
         3: ofs_v = rslb_pkg::RSLB_OFS_ORDER_CH8;
         default: ofs_v = rslb_pkg::RSLB_OFS_ORDER_CH5;
      endcase
      return ofs_v;
   endfunction : rslb_order_ofs

   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] sync;
   logic [NCH-1:0] below_now;
   logic act_now;
   logic slp_now;
   logic ch1_off_now;
   logic ch1_uv_now;

   logic act_q;
   logic slp_q;
   logic [NCH-1:0] below_q;
   logic ch1_off_q;
   logic ch1_uv_q;
   logic next_act_q;
   logic next_slp_q;
   logic [NCH-1:0] next_below_q;
   logic next_ch1_off_q;
   logic next_ch1_uv_q;

   logic [SET_W-1:0] settle;
   logic [SET_W-1:0] next_settle;
   logic armed;

   rslb_pkg::rslb_seq_t seq_kind;
   rslb_pkg::rslb_seq_t next_seq_kind;
   logic seq_sleep_entry;
   logic next_seq_sleep_entry;
   logic seq_start;
   logic [PRE_W-1:0] prescale;
   logic [PRE_W-1:0] next_prescale;
   logic [TSW-1:0] seq_timer;
   logic [TSW-1:0] next_seq_timer;

   logic [DW-1:0] order_log [NCH];
   logic [DW-1:0] next_order_log [NCH];
   logic [TSW-1:0] ts_ch1;
   logic [TSW-1:0] next_ts_ch1;

   logic [DW-1:0] rd_data;
   logic [DW-1:0] next_rd_data;
   logic rd_valid;
   logic next_rd_valid;

   // every rail and control level is a pin from outside the clock domain
   assign raw = {ch1_above_uv_low_in, ch1_below_off_in, sleep_control_in, active_control_in,
                 entry_ch_below_off_in};

   rslb_sync #(
      .WIDTH(NSYNC)
   ) u_rslb_sync (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .async_in(raw),
      .level_out(sync)
   );

   assign below_now = sync[NCH-1:0];
   assign act_now = sync[NCH];
   assign slp_now = sync[NCH+1];
   assign ch1_off_now = sync[NCH+2];
   assign ch1_uv_now = sync[NCH+3];

   // the synchroniser leaves reset at zero while idle pins sit high;
   // edges are ignored until it has filled, so no false sequence follows reset
   always_comb begin
      next_settle = settle;
      if (settle != SET_LAST) begin
         next_settle = settle + SET_W'(1);
      end
   end

   assign armed = (settle == SET_LAST);

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         settle <= '0;
      end else begin
         settle <= next_settle;
      end
   end

   always_comb begin
      next_act_q = act_now;
      next_slp_q = slp_now;
      next_below_q = below_now;
      next_ch1_off_q = ch1_off_now;
      next_ch1_uv_q = ch1_uv_now;
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         act_q <= 1'b0;
         slp_q <= 1'b0;
         below_q <= '0;
         ch1_off_q <= 1'b0;
         ch1_uv_q <= 1'b0;
      end else begin
         act_q <= next_act_q;
         slp_q <= next_slp_q;
         below_q <= next_below_q;
         ch1_off_q <= next_ch1_off_q;
         ch1_uv_q <= next_ch1_uv_q;
      end
   end

   // sequence kind and timer; sleep control falling wins over any active control edge, active control falling over sleep control rising
   always_comb begin
      next_seq_kind = seq_kind;
      next_seq_sleep_entry = seq_sleep_entry;
      next_prescale = prescale;
      next_seq_timer = seq_timer;
      seq_start = 1'b0;
      if (armed) begin
         if (rslb_fall(slp_now, slp_q)) begin
            next_seq_kind = rslb_pkg::RSLB_SEQ_FALL;
            next_seq_sleep_entry = 1'b1;
            seq_start = 1'b1;
         end else if (rslb_fall(act_now, act_q)) begin
            next_seq_kind = rslb_pkg::RSLB_SEQ_FALL;
            next_seq_sleep_entry = 1'b0;
            seq_start = 1'b1;
         end else if (rslb_rise(slp_now, slp_q) || rslb_rise(act_now, act_q)) begin
            next_seq_kind = rslb_pkg::RSLB_SEQ_RISE;
            next_seq_sleep_entry = 1'b0;
            seq_start = 1'b1;
         end
      end
      if (seq_start) begin
         next_prescale = '0;
         next_seq_timer = '0;
      end else if (seq_kind != rslb_pkg::RSLB_SEQ_NONE) begin
         if (prescale == PRE_LAST) begin
            next_prescale = '0;
            // a full timer ends the sequence rather than wrapping to small values
            if (seq_timer == TS_MAX) begin
               next_seq_kind = rslb_pkg::RSLB_SEQ_NONE;
               next_seq_sleep_entry = 1'b0;
            end else begin
               next_seq_timer = seq_timer + TSW'(1);
            end
         end else begin
            next_prescale = prescale + PRE_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         seq_kind <= rslb_pkg::RSLB_SEQ_NONE;
         seq_sleep_entry <= 1'b0;
         prescale <= '0;
         seq_timer <= '0;
      end else begin
         seq_kind <= next_seq_kind;
         seq_sleep_entry <= next_seq_sleep_entry;
         prescale <= next_prescale;
         seq_timer <= next_seq_timer;
      end
   end

   // captures look at the next sequence state, so a rail that crosses in the
   // very cycle its sequence starts is logged with timestamp zero
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         next_order_log[i] = order_log[i];
      end
      next_ts_ch1 = ts_ch1;
      if (armed && next_seq_sleep_entry && next_seq_kind == rslb_pkg::RSLB_SEQ_FALL) begin
         for (int i = 0; i < NCH; i++) begin
            if (rslb_rise(below_now[i], below_q[i])) begin
               next_order_log[i] = rail_tag_counter_in[rslb_pkg::RSLB_ORDER_MSB:rslb_pkg::RSLB_ORDER_LSB];
            end
         end
      end
      if (armed && next_seq_kind == rslb_pkg::RSLB_SEQ_FALL
          && rslb_rise(ch1_off_now, ch1_off_q)) begin
         next_ts_ch1 = next_seq_timer;
      end else if (armed && next_seq_kind == rslb_pkg::RSLB_SEQ_RISE
                   && rslb_rise(ch1_uv_now, ch1_uv_q)) begin
         next_ts_ch1 = next_seq_timer;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         for (int i = 0; i < NCH; i++) begin
            order_log[i] <= rslb_pkg::RSLB_LOG_RESET;
         end
         ts_ch1 <= {rslb_pkg::RSLB_LOG_RESET, rslb_pkg::RSLB_LOG_RESET};
      end else begin
         for (int i = 0; i < NCH; i++) begin
            order_log[i] <= next_order_log[i];
         end
         ts_ch1 <= next_ts_ch1;
      end
   end

   // read port: answer in the next cycle, data holds between reads
   always_comb begin
      next_rd_valid = rd_en_in;
      next_rd_data = rd_data;
      if (rd_en_in) begin
         next_rd_data = rslb_pkg::RSLB_UNMAPPED_READ;
         for (int i = 0; i < NCH; i++) begin
            if (rslb_hit(rd_addr_in, rslb_order_ofs(i))) begin
               next_rd_data = order_log[i];
            end
         end
         if (rslb_hit(rd_addr_in, rslb_pkg::RSLB_OFS_TS_HIGH_CH1)) begin
            next_rd_data = ts_ch1[TSW-1 -: DW];
         end
         if (rslb_hit(rd_addr_in, rslb_pkg::RSLB_OFS_TS_LOW_CH1)) begin
            next_rd_data = ts_ch1[DW-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         rd_valid <= 1'b0;
         rd_data <= rslb_pkg::RSLB_UNMAPPED_READ;
      end else begin
         rd_valid <= next_rd_valid;
         rd_data <= next_rd_data;
      end
   end

   assign rd_data_out = rd_data;
   assign rd_valid_out = rd_valid;
   assign seq_active_out = (seq_kind != rslb_pkg::RSLB_SEQ_NONE);
endmodule : rslb_log_bank

// ### verilog/rslb_pkg.sv
package rslb_pkg;
   localparam int RSLB_DATA_W = 8;
   localparam int RSLB_ADDR_W = 8;
   localparam int RSLB_TS_W = 16;
   localparam int RSLB_NUM_ENTRY_CH = 4;
   localparam int RSLB_FIRST_ENTRY_CH = 5;
   localparam logic [7:0] RSLB_OFS_ORDER_CH5 = 8'h84;
   localparam logic [7:0] RSLB_OFS_ORDER_CH6 = 8'h85;
   localparam logic [7:0] RSLB_OFS_ORDER_CH7 = 8'h86;
   localparam logic [7:0] RSLB_OFS_ORDER_CH8 = 8'h87;
   localparam logic [7:0] RSLB_OFS_TS_HIGH_CH1 = 8'h90;
   localparam logic [7:0] RSLB_OFS_TS_LOW_CH1 = 8'h91;
   localparam int RSLB_ORDER_MSB = 7;
   localparam int RSLB_ORDER_LSB = 0;
   localparam logic [7:0] RSLB_LOG_RESET = 8'h00;
   localparam logic [7:0] RSLB_UNMAPPED_READ = 8'h00;
   localparam int RSLB_CLK_HZ = 25000000;
   localparam int RSLB_STEP_TIME_US = 50;
   localparam int RSLB_STEP_CYCLES = (RSLB_CLK_HZ / 1000000) * RSLB_STEP_TIME_US;
   localparam int RSLB_SETTLE_CYCLES = 6;
   typedef enum logic [1:0] {
      RSLB_SEQ_NONE,
      RSLB_SEQ_RISE,
      RSLB_SEQ_FALL
   } rslb_seq_t;
endpackage : rslb_pkg

// ### verilog/rslb_sync.sv
`timescale 1ns/1ps
module rslb_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_level;
   // a change counts only once the second and third stage agree
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_out[i];
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         level_out <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         level_out <= next_level;
      end
   end
endmodule : rslb_sync
